// ===== hdl/mdcp_defs.svh
// How it works
// [RULE1] The port only answers frames addressed to it and never starts a transfer on its own.
// [RULE2] A read of word 0x3000 returns 1 running forward, 2 running reverse, 3 stopped; writes are refused.
// [RULE3] A read of word 0x8000 returns the active fault code, zero with no fault; writes are refused.
// [RULE4] A write to word 0x2000 decodes 1..7 as forward run, reverse run, forward jog, reverse jog, coast stop, ramp stop, fault reset.
// [RULE5] A command reaches the drive only while command_source_select holds 2.
// [RULE6] Every sent frame carries a 16-bit check value over the whole message as two bytes.
// [RULE7] Received frames have their check value recomputed and compared; a mismatch is a transmission error.
// [RULE8] The check register is preset to 0xffff before the first byte of every message.
// [RULE9] Only the eight data bits of each character enter the check calculation.
// [RULE10] Each byte is xored into the low end, then eight right shifts with 0xa001 xored in when a one falls out.
// [RULE11] The final register value is the check value, sent low byte first, then high byte.
// [RULE12] An exception reply echoes the station, returns the function code plus 0x80, one code byte and the check value.
// [RULE13] A write to a read-only word is refused with code 6; a frame with a bad check value is answered with code 3.
// [RULE14] A command value outside 1..7 is ignored and answered with the out-of-range exception.
// [RULE15] A frame with a bad check value updates nothing and issues no command.
`ifndef MDCP_DEFS_SVH
`define MDCP_DEFS_SVH

`define MDCP_REG_COMMAND 16'h2000
`define MDCP_REG_RUN_STATE 16'h3000
`define MDCP_REG_FAULT 16'h8000

`define MDCP_FC_READ 8'h03
`define MDCP_FC_WRITE 8'h06
`define MDCP_FC_EXC_FLAG 8'h80

`define MDCP_EXC_FUNCTION 8'h02
`define MDCP_EXC_CRC 8'h03
`define MDCP_EXC_ADDRESS 8'h04
`define MDCP_EXC_RANGE 8'h05
`define MDCP_EXC_READ_ONLY 8'h06

`define MDCP_RUN_FORWARD 16'h0001
`define MDCP_RUN_REVERSE 16'h0002
`define MDCP_RUN_STOPPED 16'h0003

`define MDCP_CMD_MIN 16'h0001
`define MDCP_CMD_MAX 16'h0007
`define MDCP_CMD_SRC_SERIAL 4'h2
`define MDCP_READ_COUNT 16'h0001
`define MDCP_READ_BYTES 8'h02
`define MDCP_BROADCAST 8'h00

`define MDCP_CRC_PRESET 16'hffff
`define MDCP_CRC_POLY 16'ha001
`define MDCP_CRC_BITS 8

`define MDCP_REQ_LEN 4'h8
`define MDCP_REQ_BODY 4'h6
`define MDCP_REQ_OVER 4'h9
`define MDCP_LEN_READ 3'h5
`define MDCP_LEN_WRITE 3'h6
`define MDCP_LEN_EXC 3'h3

`endif

// ===== hdl/mdcp_pkg.sv
package mdcp_pkg;

    typedef enum logic [2:0] {
        MDCP_CMD_NONE = 3'h0,
        MDCP_CMD_FWD_RUN = 3'h1,
        MDCP_CMD_REV_RUN = 3'h2,
        MDCP_CMD_FWD_JOG = 3'h3,
        MDCP_CMD_REV_JOG = 3'h4,
        MDCP_CMD_COAST_STOP = 3'h5,
        MDCP_CMD_RAMP_STOP = 3'h6,
        MDCP_CMD_FAULT_RESET = 3'h7
    } mdcp_cmd_type;

    typedef enum {
        MDCP_ST_RECEIVE,
        MDCP_ST_EVALUATE,
        MDCP_ST_SEND
    } mdcp_state_type;

    typedef struct packed {
        logic running;
        logic reverse;
        logic [15:0] fault_code;
    } mdcp_status_type;

    typedef struct packed {
        logic [7:0] station;
        logic [7:0] func;
        logic [15:0] word_addr;
        logic [15:0] value;
        logic [15:0] check;
    } mdcp_req_type;

endpackage

// ===== hdl/mdcp_crc.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdcp_defs.svh"

module mdcp_crc (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic preset,
    input wire logic feed,
    input wire logic [7:0] data_byte,
    output logic [15:0] crc
);
    logic [15:0] next_crc;

    always_comb begin
        next_crc = crc;
        if (preset) begin
            next_crc = `MDCP_CRC_PRESET; // see [RULE8]
        end else if (feed) begin
            // Whole byte in one cycle; framing bits never reach here
            next_crc = crc ^ {8'h00, data_byte}; // see [RULE9]
            for (int i = 0; i < `MDCP_CRC_BITS; i++) begin
                if (next_crc[0]) begin
                    next_crc = (next_crc >> 1) ^ `MDCP_CRC_POLY; // see [RULE10]
                end else begin
                    next_crc = next_crc >> 1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            crc <= `MDCP_CRC_PRESET;
        end else if (clk_en) begin
            crc <= next_crc;
        end
    end
endmodule // mdcp_crc

`default_nettype wire

// ===== hdl/mdcp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdcp_defs.svh"

module mdcp_port (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] station_addr,
    input wire logic [3:0] command_source_select,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire mdcp_pkg::mdcp_status_type drive_status,
    output logic drive_cmd_valid,
    output mdcp_pkg::mdcp_cmd_type drive_cmd
);
    import mdcp_pkg::*;

    mdcp_state_type state;
    mdcp_state_type next_state;
    logic [7:0] rx_buf [0:7];
    logic [7:0] next_rx_buf [0:7];
    logic [3:0] rx_count;
    logic [3:0] next_rx_count;
    logic [7:0] tx_buf [0:5];
    logic [7:0] next_tx_buf [0:5];
    logic [2:0] tx_len;
    logic [2:0] next_tx_len;
    logic [2:0] tx_idx;
    logic [2:0] next_tx_idx;
    logic next_tx_valid;
    logic [7:0] next_tx_data;
    logic next_drive_cmd_valid;
    mdcp_cmd_type next_drive_cmd;

    logic rx_crc_preset;
    logic rx_crc_feed;
    logic [15:0] rx_crc;
    logic tx_crc_preset;
    logic tx_crc_feed;
    logic [15:0] tx_crc;

    mdcp_req_type req;
    logic [15:0] run_state_word;
    logic [15:0] fault_word;
    // Frame verdict, worked out every cycle and used only in evaluate
    logic frame_whole;
    logic frame_for_us;
    logic reply;
    logic exc;
    logic [7:0] exc_code;
    logic [15:0] read_word;
    logic cmd_issue;

    // Receive side checks bytes before the two check bytes only
    mdcp_crc rx_check (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .preset(rx_crc_preset),
        .feed(rx_crc_feed),
        .data_byte(rx_data),
        .crc(rx_crc)
    );

    mdcp_crc tx_check (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .preset(tx_crc_preset),
        .feed(tx_crc_feed),
        .data_byte(next_tx_data),
        .crc(tx_crc)
    );

    assign req = {rx_buf[0], rx_buf[1], rx_buf[2], rx_buf[3], rx_buf[4], rx_buf[5], rx_buf[7], rx_buf[6]};

    always_comb begin
        if (!drive_status.running) begin
            run_state_word = `MDCP_RUN_STOPPED; // see [RULE2]
        end else if (drive_status.reverse) begin
            run_state_word = `MDCP_RUN_REVERSE; // see [RULE2]
        end else begin
            run_state_word = `MDCP_RUN_FORWARD; // see [RULE2]
        end
        fault_word = drive_status.fault_code; // see [RULE3]
    end

    // Receive path feeds the checker while collecting the body
    assign rx_crc_feed = (state == MDCP_ST_RECEIVE) && rx_valid && (rx_count < `MDCP_REQ_BODY); // see [RULE7]
    // Preset once the verdict is taken, ready for the next message
    assign rx_crc_preset = (state == MDCP_ST_EVALUATE); // see [RULE8]
    assign tx_crc_preset = (state == MDCP_ST_EVALUATE); // see [RULE8]
    assign tx_crc_feed = (state == MDCP_ST_SEND) && !tx_valid && (tx_idx < tx_len); // see [RULE6]

    // Only whole frames for this station or broadcast are acted on
    always_comb begin
        frame_whole = (rx_count == `MDCP_REQ_LEN);
        frame_for_us = (req.station == station_addr) || (req.station == `MDCP_BROADCAST); // see [RULE1]
        reply = 1'b0;
        exc = 1'b0;
        exc_code = 8'h00;
        read_word = 16'h0000;
        cmd_issue = 1'b0;
        // Short, long or foreign frames are dropped without a word
        if (frame_whole && frame_for_us) begin
            reply = (req.station == station_addr); // see [RULE1]
            if (rx_crc != req.check) begin
                // Nothing is written or issued on a corrupt frame
                exc = 1'b1; // see [RULE7]
                exc_code = `MDCP_EXC_CRC; // see [RULE13] [RULE15]
            end else if (req.func == `MDCP_FC_READ) begin
                if (req.value != `MDCP_READ_COUNT) begin
                    exc = 1'b1;
                    exc_code = `MDCP_EXC_RANGE;
                end else if (req.word_addr == `MDCP_REG_RUN_STATE) begin
                    read_word = run_state_word; // see [RULE2]
                end else if (req.word_addr == `MDCP_REG_FAULT) begin
                    read_word = fault_word; // see [RULE3]
                end else begin
                    // Command word is write-only and reads as unknown
                    exc = 1'b1;
                    exc_code = `MDCP_EXC_ADDRESS;
                end
            end else if (req.func == `MDCP_FC_WRITE) begin
                if ((req.word_addr == `MDCP_REG_RUN_STATE) || (req.word_addr == `MDCP_REG_FAULT)) begin
                    exc = 1'b1;
                    exc_code = `MDCP_EXC_READ_ONLY; // see [RULE13] [RULE2] [RULE3]
                end else if (req.word_addr != `MDCP_REG_COMMAND) begin
                    exc = 1'b1;
                    exc_code = `MDCP_EXC_ADDRESS;
                end else if ((req.value < `MDCP_CMD_MIN) || (req.value > `MDCP_CMD_MAX)) begin
                    exc = 1'b1;
                    exc_code = `MDCP_EXC_RANGE; // see [RULE14]
                end else if (command_source_select == `MDCP_CMD_SRC_SERIAL) begin // see [RULE5]
                    cmd_issue = 1'b1; // see [RULE4]
                end
            end else begin
                exc = 1'b1;
                exc_code = `MDCP_EXC_FUNCTION;
            end
        end
    end

    // Receive group: bytes kept in arrival order, count parked past the limit
    always_comb begin
        next_rx_count = rx_count;
        for (int i = 0; i < 8; i++) begin
            next_rx_buf[i] = rx_buf[i];
        end
        if (state == MDCP_ST_RECEIVE) begin
            if (rx_valid) begin
                if (rx_count < `MDCP_REQ_LEN) begin
                    next_rx_buf[rx_count[2:0]] = rx_data;
                    next_rx_count = rx_count + 4'h1;
                end else begin
                    // Too long: marked so the frame is dropped
                    next_rx_count = `MDCP_REQ_OVER;
                end
            end
        end else begin
            // Half duplex: bytes during evaluate or reply are lost
            next_rx_count = 4'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_count <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= 8'h00;
            end
        end else if (clk_en) begin
            rx_count <= next_rx_count;
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= next_rx_buf[i];
            end
        end
    end

    // Sequencing and reply group
    always_comb begin
        next_state = state;
        next_tx_len = tx_len;
        next_tx_idx = tx_idx;
        next_tx_valid = tx_valid;
        next_tx_data = tx_data;
        for (int i = 0; i < 6; i++) begin
            next_tx_buf[i] = tx_buf[i];
        end

        case (state)
            MDCP_ST_RECEIVE: begin
                if (rx_frame_end) begin
                    next_state = MDCP_ST_EVALUATE;
                end
            end

            MDCP_ST_EVALUATE: begin
                next_state = MDCP_ST_RECEIVE;
                next_tx_buf[0] = req.station;
                next_tx_buf[1] = req.func;
                if (exc) begin
                    next_tx_buf[1] = req.func | `MDCP_FC_EXC_FLAG; // see [RULE12]
                    next_tx_buf[2] = exc_code; // see [RULE12]
                    next_tx_len = `MDCP_LEN_EXC;
                end else if (req.func == `MDCP_FC_READ) begin
                    next_tx_buf[2] = `MDCP_READ_BYTES;
                    next_tx_buf[3] = read_word[15:8];
                    next_tx_buf[4] = read_word[7:0];
                    next_tx_len = `MDCP_LEN_READ;
                end else begin
                    // Write is answered by echoing the request
                    next_tx_buf[2] = rx_buf[2];
                    next_tx_buf[3] = rx_buf[3];
                    next_tx_buf[4] = rx_buf[4];
                    next_tx_buf[5] = rx_buf[5];
                    next_tx_len = `MDCP_LEN_WRITE;
                end
                next_tx_idx = 3'h0;
                if (reply) begin
                    next_state = MDCP_ST_SEND; // see [RULE1]
                end
            end

            MDCP_ST_SEND: begin
                // Half duplex: received bytes are ignored while sending
                if (!tx_valid) begin
                    next_tx_valid = 1'b1;
                    if (tx_idx < tx_len) begin
                        next_tx_data = tx_buf[tx_idx];
                    end else if (tx_idx == tx_len) begin
                        next_tx_data = tx_crc[7:0]; // see [RULE11] [RULE6]
                    end else begin
                        next_tx_data = tx_crc[15:8]; // see [RULE11] [RULE6]
                    end
                end else if (tx_ready) begin
                    next_tx_valid = 1'b0;
                    next_tx_idx = tx_idx + 3'h1;
                    if (tx_idx == tx_len + 3'h1) begin
                        next_state = MDCP_ST_RECEIVE;
                    end
                end
            end

            default: begin
                next_state = MDCP_ST_RECEIVE;
                next_tx_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= MDCP_ST_RECEIVE;
            tx_len <= 3'h0;
            tx_idx <= 3'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            for (int i = 0; i < 6; i++) begin
                tx_buf[i] <= 8'h00;
            end
        end else if (clk_en) begin
            state <= next_state;
            tx_len <= next_tx_len;
            tx_idx <= next_tx_idx;
            tx_valid <= next_tx_valid;
            tx_data <= next_tx_data;
            for (int i = 0; i < 6; i++) begin
                tx_buf[i] <= next_tx_buf[i];
            end
        end
    end

    // Command group: one strobe per accepted command, code held until the next
    // Issued before the reply starts, so a stalled link never delays the drive
    always_comb begin
        next_drive_cmd_valid = 1'b0;
        next_drive_cmd = drive_cmd;
        if ((state == MDCP_ST_EVALUATE) && cmd_issue) begin
            next_drive_cmd_valid = 1'b1; // see [RULE5] [RULE15]
            next_drive_cmd = mdcp_cmd_type'(req.value[2:0]); // see [RULE4]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            drive_cmd_valid <= 1'b0;
            drive_cmd <= MDCP_CMD_NONE;
        end else if (clk_en) begin
            drive_cmd_valid <= next_drive_cmd_valid;
            drive_cmd <= next_drive_cmd;
        end
    end
endmodule // mdcp_port

`default_nettype wire

// ===== tb/mdcp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mdcp_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] station_addr,
    input wire logic [3:0] command_source_select,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire mdcp_pkg::mdcp_status_type drive_status,
    input wire logic drive_cmd_valid,
    input wire mdcp_pkg::mdcp_cmd_type drive_cmd
);
    import mdcp_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    chk_cmd_single_pulse: assert property (drive_cmd_valid |=> !drive_cmd_valid)
        else $error("command strobe longer than one cycle");
    chk_cmd_code_valid: assert property (drive_cmd_valid |-> drive_cmd != MDCP_CMD_NONE)
        else $error("command strobe with empty code");
    chk_cmd_source_serial: assert property (drive_cmd_valid |-> $past(command_source_select) == 4'h2)
        else $error("command issued with another source selected");
    chk_cmd_after_frame: assert property (drive_cmd_valid && $past(clk_en) && $past(clk_en, 2)
        |-> $past(rx_frame_end, 2)) else $error("command not two cycles after frame end");
    chk_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped or changed before accept");
    chk_tx_byte_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("no idle cycle after accepted byte");
    chk_reply_cause: assert property ($rose(tx_valid)
        |-> $past(rx_frame_end, 3) || $past(tx_valid && tx_ready, 2)) else $error("unsolicited reply byte");
    chk_cmd_code_hold: assert property ($changed(drive_cmd) |-> drive_cmd_valid)
        else $error("command code changed without strobe");
endmodule // mdcp_monitor
bind mdcp_port mdcp_monitor mdcp_monitor_i (.mclk, .reset, .clk_en, .station_addr, .command_source_select,
    .rx_valid, .rx_data, .rx_frame_end, .tx_valid, .tx_data, .tx_ready, .drive_status, .drive_cmd_valid, .drive_cmd);
`default_nettype wire

// ===== tb/mdcp_master.sv
`timescale 1ns/1ps
`default_nettype none
module mdcp_master (
    input wire logic mclk,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_end
);
    logic [7:0] rxq[$];
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_frame_end = 1'b0;
    end
    always @(posedge mclk) begin
        tx_ready <= !stall;
        if (tx_valid && tx_ready)
            rxq.push_back(tx_data);
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // Bad flag flips one check bit so the frame is corrupt on purpose
    task automatic send(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0, bad};
        q = {q, c[7:0], c[15:8]};
        foreach (q[i]) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_frame_end <= (i == q.size() - 1);
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_frame_end <= 1'b0;
        // Stale byte never lingers on the idle line
        rx_data <= ~q[q.size() - 1];
    endtask
endmodule // mdcp_master
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mdcp_pkg::*;
    typedef logic [7:0] mdcp_bq_type[$];
    logic mclk, reset, clk_en, rx_valid, rx_frame_end, tx_valid, tx_ready, drive_cmd_valid, stall, rb;
    logic [7:0] station_addr, rx_data, tx_data, rf;
    logic [3:0] command_source_select;
    logic [15:0] ra, rv;
    logic [2:0] last_cmd;
    mdcp_status_type drive_status;
    mdcp_cmd_type drive_cmd;
    integer seed = 32'h294ee10f;
    int n_errors = 0, compares = 0, ncmd = 0;
    mdcp_port mdcp_port_i (.mclk, .reset, .clk_en, .station_addr, .command_source_select, .rx_valid, .rx_data,
        .rx_frame_end, .tx_valid, .tx_data, .tx_ready, .drive_status, .drive_cmd_valid, .drive_cmd);
    mdcp_master mdcp_master_i (.mclk, .stall, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_frame_end);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        stall <= ($random(seed) % 3) == 0;
        if (drive_cmd_valid === 1'b1) begin
            ncmd <= ncmd + 1;
            last_cmd <= drive_cmd;
        end
    end
    task automatic compare(string nm, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic mdcp_bq_type expect_reply(logic [7:0] fc, logic [15:0] a, logic [15:0] v, bit bad);
        mdcp_bq_type q;
        logic [7:0] x;
        logic [15:0] rd, c;
        rd = (a == 16'h8000) ? drive_status.fault_code : drive_status.running ?
            {14'h0, drive_status.reverse, !drive_status.reverse} : 16'h3;
        x = 8'h00;
        if (bad) x = 8'h03;
        else if (fc == 8'h03) x = (v != 16'h1) ? 8'h05 : (a == 16'h3000 || a == 16'h8000) ? 8'h00 : 8'h04;
        else if (fc != 8'h06) x = 8'h02;
        else if (a == 16'h3000 || a == 16'h8000) x = 8'h06;
        else if (a != 16'h2000) x = 8'h04;
        else if (v == 16'h0 || v > 16'h7) x = 8'h05;
        q = {station_addr, (x != 8'h00) ? (fc | 8'h80) : fc};
        if (x != 8'h00) q.push_back(x);
        else if (fc == 8'h03) q = {q, 8'h02, rd[15:8], rd[7:0]};
        else q = {q, a[15:8], a[7:0], v[15:8], v[7:0]};
        c = mdcp_master_i.crc16(q);
        return {q, c[7:0], c[15:8]};
    endfunction
    task automatic xact(logic [7:0] st, logic [7:0] fc, logic [15:0] a, logic [15:0] v, bit bad);
        mdcp_bq_type e;
        int k, n0, ne;
        bit act;
        @(posedge mclk);
        e = expect_reply(fc, a, v, bad);
        ne = (st == station_addr) ? e.size() : 0;
        act = (st == station_addr || st == 8'h00) && e[1] == 8'h06 && a == 16'h2000 && command_source_select == 4'h2;
        n0 = ncmd;
        mdcp_master_i.rxq.delete();
        mdcp_master_i.send({st, fc, a[15:8], a[7:0], v[15:8], v[7:0]}, bad);
        for (k = 0; k < 500 && mdcp_master_i.rxq.size() < ne; k++) @(posedge mclk);
        if (k == 500) begin
            n_errors++;
            $display("MISMATCH reply wait expected %0d bytes seen %0d", ne, mdcp_master_i.rxq.size());
            end_sim();
        end
        repeat ((ne == 0) ? 20 : 4) @(posedge mclk);
        compare("reply length", 16'(ne), 16'(mdcp_master_i.rxq.size()));
        for (k = 0; k < ne; k++) begin
            compare("reply byte", {8'h0, e[k]}, {8'h0, mdcp_master_i.rxq[k]});
        end
        compare("command count", {15'h0, act}, 16'(ncmd - n0));
        if (act) compare("command code", v, {13'h0, last_cmd});
        $display("test done st %h fc %h addr %h val %h bad %0d", st, fc, a, v, bad);
    endtask
    // Frame that must be dropped whole: no reply byte and no command strobe
    task automatic quiet(mdcp_bq_type q, string nm);
        int n0;
        n0 = ncmd;
        @(posedge mclk);
        mdcp_master_i.rxq.delete();
        mdcp_master_i.send(q, 1'b0);
        repeat (20) @(posedge mclk);
        compare("dropped reply length", 16'h0, 16'(mdcp_master_i.rxq.size()));
        compare("dropped command count", 16'h0, 16'(ncmd - n0));
        $display("test done %s", nm);
    endtask
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        stall = 1'b0;
        station_addr = 8'h5a;
        command_source_select = 4'h2;
        drive_status = '0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        for (int v = 0; v < 9; v++) xact(8'h5a, 8'h06, 16'h2000, 16'(v), 1'b0);
        command_source_select <= 4'($random(seed)) | 4'h1;
        xact(8'h5a, 8'h06, 16'h2000, 16'h0001, 1'b0);
        command_source_select <= 4'h2;
        for (int s = 0; s < 3; s++) begin
            drive_status <= {s != 2, s == 1, (s == 0) ? 16'h0 : 16'($random(seed))};
            xact(8'h5a, 8'h03, 16'h3000, 16'h0001, 1'b0);
            xact(8'h5a, 8'h03, 16'h8000, 16'h0001, 1'b0);
        end
        xact(8'h5a, 8'h06, 16'h3000, 16'h0001, 1'b0);
        xact(8'h5a, 8'h06, 16'h8000, 16'h0000, 1'b0);
        xact(8'h5a, 8'h06, 16'h2000, 16'h0007, 1'b1);
        xact(8'h5a, 8'h10, 16'h2000, 16'h0001, 1'b0);
        xact(8'h5a, 8'h03, 16'h2000, 16'h0001, 1'b0);
        xact(8'h5a, 8'h03, 16'h3000, 16'h0002, 1'b0);
        xact(8'h5a, 8'h06, 16'h2001, 16'h0001, 1'b0);
        xact(8'h33, 8'h06, 16'h2000, 16'h0001, 1'b0);
        xact(8'h00, 8'h06, 16'h2000, 16'h0006, 1'b0);
        xact(8'h00, 8'h06, 16'h2000, 16'h0005, 1'b1);
        quiet({8'h5a, 8'h06, 8'h20, 8'h00, 8'h00}, "short frame");
        quiet({8'h5a, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01, 8'h00}, "long frame");
        // Frozen port must ignore a whole frame and pick up cleanly afterwards
        clk_en <= 1'b0;
        quiet({8'h5a, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01}, "frozen frame");
        clk_en <= 1'b1;
        xact(8'h5a, 8'h06, 16'h2000, 16'h0002, 1'b0);
        for (int i = 0; i < 30; i++) begin
            ra = ($random(seed) & 1) ? 16'h2000 : (($random(seed) & 1) ? 16'h3000 : 16'h8000);
            rf = ($random(seed) & 1) ? 8'h03 : 8'h06;
            rv = (rf == 8'h03 || ra != 16'h2000) ? 16'h1 : 16'($unsigned($random(seed)) % 10);
            rb = ($random(seed) & 7) == 0;
            drive_status <= 18'($random(seed));
            command_source_select <= (($random(seed) & 3) == 0) ? 4'h6 : 4'h2;
            xact(8'h5a, rf, ra, rv, rb);
        end
        end_sim();
    end
endmodule // testbench
`default_nettype wire
